// ==== hw/cache_line_pkg.sv ====
// Constants, field layout and carrier types for the cache line direct access block
package cache_line_pkg;

  // Geometry
  localparam int LINE_COUNT = 16;
  localparam int IDX_W      = 4;
  localparam int TAG_W      = 20;
  localparam int MASK_W     = 11;
  localparam int WORDS      = 4;
  localparam int ADDR_W     = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ACCESS    = 16'h4010;
  localparam logic [ADDR_W-1:0] OFF_TAG       = 16'h4020;
  localparam logic [ADDR_W-1:0] OFF_MASK      = 16'h4030;
  localparam logic [ADDR_W-1:0] OFF_WORD0     = 16'h4040;
  localparam logic [ADDR_W-1:0] OFF_WORD_STEP = 16'h0010;

  // Access register fields
  localparam int ACC_PERMIT_BIT = 31;
  localparam int ACC_IDX_LSB    = 0;

  // Tag register fields
  localparam int TAG_REGION_BIT = 31;
  localparam int TAG_ADDR_LSB   = 4;
  localparam int TAG_VALID_BIT  = 3;
  localparam int TAG_LOCK_BIT   = 2;
  localparam int TAG_KIND_BIT   = 1;

  // Mask register field and the only lines that may hold a mask
  localparam int               MASK_LSB    = 5;
  localparam logic [IDX_W-1:0] MASK_LINE_A = 4'hA;
  localparam logic [IDX_W-1:0] MASK_LINE_B = 4'hB;

  // Reset values
  localparam logic              PERMIT_RESET = 1'b0;
  localparam logic [IDX_W-1:0]  IDX_RESET    = 4'h0;
  localparam logic              REGION_RESET = 1'b0;
  localparam logic              VALID_RESET  = 1'b0;
  localparam logic              LOCK_RESET   = 1'b0;
  localparam logic              KIND_RESET   = 1'b1;
  localparam logic [MASK_W-1:0] MASK_RESET   = 11'h000;

  // Memory regions; tag bits sit at address bits 23:4, region in 31:24
  localparam logic [31:0] REGION_FLASH_BASE = 32'h1D000000;
  localparam logic [31:0] REGION_BOOT_BASE  = 32'h1FC00000;
  localparam int          REGION_LSB        = 24;
  localparam int          LINE_ADDR_LSB     = 4;

  // One line's tag state
  typedef struct packed {
    logic             region;
    logic [TAG_W-1:0] addr;
    logic             valid;
    logic             lock;
    logic             kind;
  } line_tag_t;

  // Fetch presented for hit detection
  typedef struct packed {
    logic        valid;
    logic        isInstr;
    logic [31:0] addr;
  } fetch_req_t;

  // Registered lookup answer
  typedef struct packed {
    logic             hit;
    logic [IDX_W-1:0] line;
  } lookup_t;

endpackage

// ==== hw/cache_line_direct_access.sv ====
// Direct software access to prefetch cache lines, with hit detection and victim choice
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module cache_line_direct_access (
  input  wire logic                                    clk,         // System clock, 10 MHz
  input  wire logic                                    reset,       // Synchronous reset, active high
  input  wire logic [cache_line_pkg::ADDR_W-1:0]       regAddr,     // Register byte address
  input  wire logic [31:0]                             regWrData,   // Register write data
  input  wire logic                                    regWrite,    // Write strobe
  input  wire logic                                    regRead,     // Read strobe
  output logic      [31:0]                             regRdData,   // Read data, cycle after strobe
  input  wire logic                                    codeProtect, // Hides cached words from reads
  input  wire cache_line_pkg::fetch_req_t              fetchReq,    // Fetch for hit detection
  output cache_line_pkg::lookup_t                      lookup,      // Hit answer, one cycle later
  input  wire logic                                    refillDone,  // Pulse: victim line was refilled
  output logic      [cache_line_pkg::IDX_W-1:0]        victimLine,  // Next line to replace
  output logic                                         victimValid  // High when an unlocked line exists
);

  localparam int LC = cache_line_pkg::LINE_COUNT;
  localparam int NW = cache_line_pkg::WORDS;

  // Access register state
  logic                              permit_r;
  logic                              permit_nxt;
  logic [cache_line_pkg::IDX_W-1:0]  index_r;
  logic [cache_line_pkg::IDX_W-1:0]  index_nxt;

  // Per-line storage
  cache_line_pkg::line_tag_t         tagArr_r   [LC];
  cache_line_pkg::line_tag_t         tagArr_nxt [LC];
  logic [cache_line_pkg::MASK_W-1:0] maskArr_r  [LC];
  logic [cache_line_pkg::MASK_W-1:0] maskArr_nxt[LC];
  logic [31:0]                       wordArr_r  [LC][NW];
  logic [31:0]                       wordArr_nxt[LC][NW];

  // Read path, lookup and victim state
  logic [31:0]                       rdData_r;
  logic [31:0]                       rdData_nxt;
  cache_line_pkg::lookup_t           lookup_r;
  cache_line_pkg::lookup_t           lookup_nxt;
  logic [cache_line_pkg::IDX_W-1:0]  victimPtr_r;
  logic [cache_line_pkg::IDX_W-1:0]  victimPtr_nxt;
  logic [cache_line_pkg::IDX_W-1:0]  victimSel;
  logic                              victimAny;

  // Decoded register selects, shared by the write and read paths, and the mask line check used by writes only
  logic                              selAccess;
  logic                              selTag;
  logic                              selMask;
  logic                              maskLine;

  // Byte address of cached word w
  function automatic logic [cache_line_pkg::ADDR_W-1:0] wordOffset(input int w);
    logic [cache_line_pkg::ADDR_W-1:0] step;
    step = cache_line_pkg::OFF_WORD_STEP * cache_line_pkg::ADDR_W'(w);
    return cache_line_pkg::OFF_WORD0 + step;
  endfunction

  // Pack a tag entry into its register image, unimplemented bits zero
  function automatic logic [31:0] tagImage(input cache_line_pkg::line_tag_t t);
    logic [31:0] img;
    img = 32'h00000000;
    img[cache_line_pkg::TAG_REGION_BIT] = t.region;
    img[cache_line_pkg::TAG_ADDR_LSB +: cache_line_pkg::TAG_W] = t.addr;
    img[cache_line_pkg::TAG_VALID_BIT] = t.valid;
    img[cache_line_pkg::TAG_LOCK_BIT] = t.lock;
    img[cache_line_pkg::TAG_KIND_BIT] = t.kind;
    return img;
  endfunction

  // Does one line hit the fetch; the tag is compared untranslated
  function automatic logic lineHit(input cache_line_pkg::line_tag_t t,
                                   input logic [cache_line_pkg::MASK_W-1:0] m,
                                   input cache_line_pkg::fetch_req_t f);
    logic [cache_line_pkg::TAG_W-1:0] addrTag;
    logic [cache_line_pkg::TAG_W-1:0] force1;
    logic [7:0]                       base;
    addrTag = f.addr[cache_line_pkg::LINE_ADDR_LSB +: cache_line_pkg::TAG_W];
    force1 = {{(cache_line_pkg::TAG_W - cache_line_pkg::MASK_W){1'b0}}, m};
    base = t.region ? cache_line_pkg::REGION_FLASH_BASE[cache_line_pkg::REGION_LSB +: 8]
                    : cache_line_pkg::REGION_BOOT_BASE[cache_line_pkg::REGION_LSB +: 8];
    return t.valid
        && (t.kind == f.isInstr)
        && (f.addr[cache_line_pkg::REGION_LSB +: 8] == base)
        && (((addrTag ^ t.addr) & ~force1) == '0);
  endfunction

  // One decode feeds both paths, so a map change cannot split them apart
  always_comb
  begin
    selAccess = (regAddr == cache_line_pkg::OFF_ACCESS);
    selTag    = (regAddr == cache_line_pkg::OFF_TAG);
    selMask   = (regAddr == cache_line_pkg::OFF_MASK);
    // Only two lines have writable mask storage; the rest keep masking off
    maskLine  = (index_r == cache_line_pkg::MASK_LINE_A) || (index_r == cache_line_pkg::MASK_LINE_B);
  end

  // Register writes; the index register is always writable, line state only under permit
  always_comb
  begin
    permit_nxt  = permit_r;
    index_nxt   = index_r;
    tagArr_nxt  = tagArr_r;
    maskArr_nxt = maskArr_r;
    wordArr_nxt = wordArr_r;
    if (regWrite)
    begin
      if (selAccess)
      begin
        permit_nxt = regWrData[cache_line_pkg::ACC_PERMIT_BIT];
        index_nxt  = regWrData[cache_line_pkg::ACC_IDX_LSB +: cache_line_pkg::IDX_W];
      end
      if (permit_r)
      begin
        if (selTag)
        begin
          tagArr_nxt[index_r].region = regWrData[cache_line_pkg::TAG_REGION_BIT];
          tagArr_nxt[index_r].addr   = regWrData[cache_line_pkg::TAG_ADDR_LSB +: cache_line_pkg::TAG_W];
          tagArr_nxt[index_r].valid  = regWrData[cache_line_pkg::TAG_VALID_BIT];
          tagArr_nxt[index_r].lock   = regWrData[cache_line_pkg::TAG_LOCK_BIT];
          tagArr_nxt[index_r].kind   = regWrData[cache_line_pkg::TAG_KIND_BIT];
        end
        // Other lines have no mask storage that software can reach
        if (selMask && maskLine)
        begin
          maskArr_nxt[index_r] = regWrData[cache_line_pkg::MASK_LSB +: cache_line_pkg::MASK_W];
        end
        for (int w = 0; w < NW; w++)
        begin
          if (regAddr == wordOffset(w))
          begin
            wordArr_nxt[index_r][w] = regWrData;
          end
        end
      end
    end
  end

  // Read mux; data appears only in the cycle after the strobe, unmapped reads give zero
  always_comb
  begin
    rdData_nxt = 32'h00000000;
    if (regRead)
    begin
      if (selAccess)
      begin
        rdData_nxt[cache_line_pkg::ACC_PERMIT_BIT] = permit_r;
        rdData_nxt[cache_line_pkg::ACC_IDX_LSB +: cache_line_pkg::IDX_W] = index_r;
      end
      if (selTag)
      begin
        rdData_nxt = tagImage(tagArr_r[index_r]);
      end
      if (selMask)
      begin
        rdData_nxt[cache_line_pkg::MASK_LSB +: cache_line_pkg::MASK_W] = maskArr_r[index_r];
      end
      // Protection hides the cached program image, not the tags
      for (int w = 0; w < NW; w++)
      begin
        if (regAddr == wordOffset(w) && !codeProtect)
        begin
          rdData_nxt = wordArr_r[index_r][w];
        end
      end
    end
  end

  // Hit detection; the lowest matching line wins if software left duplicates
  always_comb
  begin
    lookup_nxt = '0;
    for (int i = LC - 1; i >= 0; i--)
    begin
      if (fetchReq.valid && lineHit(tagArr_r[i], maskArr_r[i], fetchReq))
      begin
        lookup_nxt.hit  = 1'b1;
        lookup_nxt.line = cache_line_pkg::IDX_W'(i);
      end
    end
  end

  // Round-robin victim search starting at the pointer, skipping locked lines
  always_comb
  begin
    logic [cache_line_pkg::IDX_W-1:0] cand;
    cand          = '0;
    victimSel     = victimPtr_r;
    victimAny     = 1'b0;
    victimPtr_nxt = victimPtr_r;
    for (int j = LC - 1; j >= 0; j--)
    begin
      cand = victimPtr_r + cache_line_pkg::IDX_W'(j);
      if (!tagArr_r[cand].lock)
      begin
        victimSel = cand;
        victimAny = 1'b1;
      end
    end
    if (refillDone && victimAny)
    begin
      victimPtr_nxt = victimSel + 4'h1;
    end
  end

  // Access register; cleared so that no line is writable until software asks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      permit_r <= cache_line_pkg::PERMIT_RESET;
      index_r  <= cache_line_pkg::IDX_RESET;
    end
    else
    begin
      permit_r <= permit_nxt;
      index_r  <= index_nxt;
    end
  end

  // Tag flags and masks take reset values; the tag address is left undefined
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < LC; i++)
      begin
        tagArr_r[i].region <= cache_line_pkg::REGION_RESET;
        tagArr_r[i].valid  <= cache_line_pkg::VALID_RESET;
        tagArr_r[i].lock   <= cache_line_pkg::LOCK_RESET;
        tagArr_r[i].kind   <= cache_line_pkg::KIND_RESET;
        maskArr_r[i]       <= cache_line_pkg::MASK_RESET;
      end
    end
    else
    begin
      tagArr_r  <= tagArr_nxt;
      maskArr_r <= maskArr_nxt;
    end
  end

  // Read data lasts one cycle, then falls back to zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdData_r <= 32'h00000000;
    end
    else
    begin
      rdData_r <= rdData_nxt;
    end
  end

  // Lookup answer; a stale hit must not survive reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lookup_r <= '0;
    end
    else
    begin
      lookup_r <= lookup_nxt;
    end
  end

  // Round-robin pointer; starts at line zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      victimPtr_r <= 4'h0;
    end
    else
    begin
      victimPtr_r <= victimPtr_nxt;
    end
  end

  // Data words have no reset; a reset cycle must not look like a write
  always_ff @(posedge clk)
  begin
    if (!reset)
    begin
      wordArr_r <= wordArr_nxt;
    end
  end

  // Outputs
  assign regRdData   = rdData_r;
  assign lookup      = lookup_r;
  assign victimLine  = victimSel;
  assign victimValid = victimAny;

endmodule

`default_nettype wire

// ==== verification/cache_line_direct_access_properties.sv ====
// Port-level assertions for the cache line direct access block
`timescale 1ns/1ps
`default_nettype none
module cache_line_direct_access_properties (
  input wire logic                                clk,         // System clock
  input wire logic                                reset,       // Synchronous reset
  input wire logic [cache_line_pkg::ADDR_W-1:0]   regAddr,     // Register address
  input wire logic [31:0]                         regWrData,   // Write data
  input wire logic                                regWrite,    // Write strobe
  input wire logic                                regRead,     // Read strobe
  input wire logic [31:0]                         regRdData,   // Read data
  input wire logic                                codeProtect, // Word read hiding
  input wire cache_line_pkg::fetch_req_t          fetchReq,    // Fetch request
  input wire cache_line_pkg::lookup_t             lookup,      // Hit answer
  input wire logic                                refillDone,  // Refill pulse
  input wire logic [cache_line_pkg::IDX_W-1:0]    victimLine,  // Victim choice
  input wire logic                                victimValid  // Victim exists
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [cache_line_pkg::IDX_W-1:0] idx_r;
  logic [cache_line_pkg::IDX_W-1:0] idx_nxt;
  // Shadow of the line index, needed to know which mask reads must be zero
  always_comb
  begin
    idx_nxt = idx_r;
    if (regWrite && regAddr == cache_line_pkg::OFF_ACCESS)
      idx_nxt = regWrData[3:0];
  end
  always_ff @(posedge clk)
  begin
    idx_r <= reset ? 4'h0 : idx_nxt;
  end
  // Register read side
  word_hide_a: assert property (regRead && codeProtect && regAddr >= cache_line_pkg::OFF_WORD0
    && regAddr <= 16'h4070 |=> regRdData == 32'h00000000) else $error("protected word was revealed");
  acc_zero_a: assert property (regRead && regAddr == cache_line_pkg::OFF_ACCESS
    |=> regRdData[30:4] == 27'h0000000) else $error("access register spare bits not zero");
  tag_zero_a: assert property (regRead && regAddr == cache_line_pkg::OFF_TAG
    |=> regRdData[30:24] == 7'h00 && !regRdData[0]) else $error("tag register spare bits not zero");
  mask_zero_a: assert property (regRead && regAddr == cache_line_pkg::OFF_MASK
    |=> regRdData[31:16] == 16'h0000 && regRdData[4:0] == 5'h00) else $error("mask spare bits not zero");
  mask_line_a: assert property (regRead && regAddr == cache_line_pkg::OFF_MASK && idx_r != 4'hA
    && idx_r != 4'hB |=> regRdData == 32'h00000000) else $error("mask nonzero on unmaskable line");
  rd_stands_a: assert property (regRead ##1 !regRead |=> regRdData == 32'h00000000)
    else $error("read data outlived its cycle");
  // Hit detection
  region_miss_a: assert property (fetchReq.valid && fetchReq.addr[31:24] != 8'h1D
    && fetchReq.addr[31:24] != 8'h1F |=> !lookup.hit) else $error("hit outside cached regions");
  hit_cause_a: assert property (lookup.hit |-> $past(fetchReq.valid))
    else $error("hit without a fetch");
  // Victim choice
  victim_rst_a: assert property (disable iff (1'b0) reset |=> victimValid && victimLine == 4'h0)
    else $error("victim state wrong after reset");
  victim_hold_a: assert property (refillDone && !victimValid && !regWrite |=> $stable(victimLine))
    else $error("victim moved with all lines locked");
  hit_seen_c: cover property (lookup.hit);
  hidden_read_c: cover property (regRead && codeProtect);
  all_locked_c: cover property (refillDone && !victimValid);
endmodule
`default_nettype wire

// ==== verification/cache_line_direct_access_test.sv ====
// Self-checking testbench for the cache line direct access block
`timescale 1ns/1ps
`default_nettype none
module cache_line_direct_access_test;
  logic                              clk = 1'b0;
  logic                              reset = 1'b1;
  logic [cache_line_pkg::ADDR_W-1:0] regAddr = 16'h0000;
  logic [31:0]                       regWrData = 32'h00000000;
  logic                              regWrite = 1'b0;
  logic                              regRead = 1'b0;
  logic [31:0]                       regRdData;
  logic                              codeProtect = 1'b0;
  cache_line_pkg::fetch_req_t        fetchReq = '0;
  cache_line_pkg::lookup_t           lookup;
  logic                              refillDone = 1'b0;
  logic [3:0]                        victimLine;
  logic                              victimValid;
  logic [31:0]                       d;
  int                                fails = 0;
  int                                n_compared = 0;
  cache_line_direct_access i_cache_line_direct_access (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .codeProtect(codeProtect), .fetchReq(fetchReq), .lookup(lookup), .refillDone(refillDone),
    .victimLine(victimLine), .victimValid(victimValid));
  // 100 ns period
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic sel(input logic [3:0] i);
    wr(cache_line_pkg::OFF_ACCESS, {28'h8000000, i});
  endtask
  // Misses compare the hit flag only, the line field is then meaningless
  task automatic look(input logic [31:0] a, input logic ins, input logic h, input logic [3:0] l);
    @(posedge clk);
    fetchReq <= '{1'b1, ins, a};
    @(posedge clk);
    fetchReq.valid <= 1'b0;
    #1 cmp({27'h0, lookup.hit, lookup.hit ? lookup.line : 4'h0}, {27'h0, h, h ? l : 4'h0});
  endtask
  function automatic logic [31:0] tagv(logic r, logic [19:0] a, logic v, logic k, logic t);
    return {r, 7'h00, a, v, k, t, 1'b0};
  endfunction
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    rd(cache_line_pkg::OFF_ACCESS);
    cmp(d, 32'h00000000);
    rd(cache_line_pkg::OFF_TAG);
    cmp(d & 32'hFF00000F, 32'h00000002);
    rd(cache_line_pkg::OFF_MASK);
    cmp(d, 32'h00000000);
    rd(16'h4080);
    cmp(d, 32'h00000000);
    cmp({27'h0, victimValid, victimLine}, 32'h00000010);
    $display("reset values done");
  endtask
  task automatic t_access;
    // Spare bits are written as zero, as software must
    wr(cache_line_pkg::OFF_ACCESS, 32'h80000003);
    rd(cache_line_pkg::OFF_ACCESS);
    cmp(d, 32'h80000003);
    wr(cache_line_pkg::OFF_ACCESS, 32'h00000003);
    wr(cache_line_pkg::OFF_TAG, tagv(1'b1, 20'h12345, 1'b1, 1'b0, 1'b1));
    rd(cache_line_pkg::OFF_TAG);
    cmp(d & 32'hFF00000F, 32'h00000002);
    $display("access and permit done");
  endtask
  task automatic t_tag;
    sel(4'h3);
    wr(cache_line_pkg::OFF_TAG, tagv(1'b1, 20'h12345, 1'b1, 1'b0, 1'b1));
    rd(cache_line_pkg::OFF_TAG);
    cmp(d, tagv(1'b1, 20'h12345, 1'b1, 1'b0, 1'b1));
    look(32'h1D123450, 1'b1, 1'b1, 4'h3);
    look(32'h1D123450, 1'b0, 1'b0, 4'h0);
    look(32'h1F123450, 1'b1, 1'b0, 4'h0);
    sel(4'h4);
    wr(cache_line_pkg::OFF_TAG, tagv(1'b0, 20'hC0ABC, 1'b1, 1'b0, 1'b0));
    look(32'h1FC0ABC0, 1'b0, 1'b1, 4'h4);
    wr(cache_line_pkg::OFF_TAG, tagv(1'b0, 20'hC0ABC, 1'b0, 1'b0, 1'b0));
    look(32'h1FC0ABC0, 1'b0, 1'b0, 4'h0);
    $display("tag and hit done");
  endtask
  task automatic t_mask;
    sel(4'hA);
    wr(cache_line_pkg::OFF_TAG, tagv(1'b1, 20'h00100, 1'b1, 1'b0, 1'b1));
    wr(cache_line_pkg::OFF_MASK, 32'h0000FFE0);
    rd(cache_line_pkg::OFF_MASK);
    cmp(d, 32'h0000FFE0);
    look(32'h1D003FF0, 1'b1, 1'b1, 4'hA);
    look(32'h1D009000, 1'b1, 1'b0, 4'h0);
    sel(4'h2);
    wr(cache_line_pkg::OFF_MASK, 32'h0000FFE0);
    rd(cache_line_pkg::OFF_MASK);
    cmp(d, 32'h00000000);
    $display("mask done");
  endtask
  task automatic t_words;
    sel(4'h5);
    for (int w = 0; w < 4; w++)
    begin
      wr(16'h4040 + 16'(w * 16), 32'hA5A50000 + w);
    end
    for (int w = 0; w < 4; w++)
    begin
      rd(16'h4040 + 16'(w * 16));
      cmp(d, 32'hA5A50000 + w);
    end
    @(posedge clk) codeProtect <= 1'b1;
    for (int w = 0; w < 4; w++)
    begin
      rd(16'h4040 + 16'(w * 16));
      cmp(d, 32'h00000000);
    end
    @(posedge clk) codeProtect <= 1'b0;
    wr(cache_line_pkg::OFF_ACCESS, 32'h00000005);
    wr(cache_line_pkg::OFF_WORD0, 32'hDEAD0000);
    rd(cache_line_pkg::OFF_WORD0);
    cmp(d, 32'hA5A50000);
    $display("data words done");
  endtask
  task automatic t_victim;
    // Lock lines 0 and 1, so the search from pointer 0 lands on line 2
    for (int i = 0; i < 2; i++)
    begin
      sel(4'(i));
      wr(cache_line_pkg::OFF_TAG, tagv(1'b0, 20'h0, 1'b0, 1'b1, 1'b1));
    end
    #1 cmp({27'h0, victimValid, victimLine}, 32'h00000012);
    @(posedge clk) refillDone <= 1'b1;
    @(posedge clk) refillDone <= 1'b0;
    #1 cmp({27'h0, victimValid, victimLine}, 32'h00000013);
    for (int i = 0; i < 16; i++)
    begin
      sel(4'(i));
      wr(cache_line_pkg::OFF_TAG, tagv(1'b0, 20'h0, 1'b0, 1'b1, 1'b1));
    end
    @(posedge clk) refillDone <= 1'b1;
    @(posedge clk) refillDone <= 1'b0;
    #1 cmp({31'h0, victimValid}, 32'h00000000);
    $display("victim choice done");
  endtask
  // Whole run needs well under 2000 cycles
  initial
  begin
    #1_000_000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_access();
    t_tag();
    t_mask();
    t_words();
    t_victim();
    stop_test();
  end
endmodule
bind cache_line_direct_access cache_line_direct_access_properties i_cache_line_direct_access_properties (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .codeProtect(codeProtect), .fetchReq(fetchReq),
  .lookup(lookup), .refillDone(refillDone), .victimLine(victimLine), .victimValid(victimValid));
`default_nettype wire
